// ===== src/dnc_pkg.sv
// Timing constants and encodings for the nibble DRAM cycle controller
package dnc_pkg;
  // ----------------------------------------------------------------
  // Clock and array shape
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int ROW_BITS = 7;
  localparam int COL_BITS = 7;
  localparam int DQ_BITS = 4;
  localparam int ROW_COUNT = 128;
  localparam int WAKE_CYCLES = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Times as printed, faster grade
  // ----------------------------------------------------------------
  localparam int ROW_TO_COLUMN_DELAY_NS = 30;
  localparam int ROW_ACCESS_NS = 120;
  localparam int RAS_LOW_NS = 120;
  localparam int RAS_HIGH_NS = 90;
  localparam int RD_CYCLE_NS = 220;
  localparam int RMW_CYCLE_NS = 295;
  localparam int RMW_RAS_LOW_NS = 195;
  localparam int ROW_TO_WRITE_DELAY_NS = 150;
  localparam int GATE_HIGH_TO_DATA_DELAY_NS = 25;
  localparam int WRITE_PULSE_NS = 40;
  localparam int REFRESH_PERIOD_US = 2000;
  localparam int POWERUP_US = 500;
  localparam int IDLE_LIMIT_US = 2000;

  // ----------------------------------------------------------------
  // Derived cycle counts (least times round up, longest round down)
  // ----------------------------------------------------------------
  localparam int RCD_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAC_CYC = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RASL_CYC = (RAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (RAS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC = (RD_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RWC_CYC = (RMW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RMW_RASL_CYC = (RMW_RAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RWD_CYC = (ROW_TO_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEHD_CYC = (GATE_HIGH_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pin-to-register latency is one output flop plus two input sync flops
  localparam int SAMPLE_T = RAC_CYC + SYNC_STAGES + 2;
  localparam int RD_END_T = SAMPLE_T + 1;
  localparam int WR_END_T = RASL_CYC;
  localparam int RMW_WE_T = SAMPLE_T + 1 + OEHD_CYC;
  localparam int RMW_END_T = RMW_WE_T + WP_CYC;
  localparam int REF_INT_CYC = (REFRESH_PERIOD_US * 1000 / ROW_COUNT) / CLK_PERIOD_NS;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_LIMIT_CYC = (IDLE_LIMIT_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam int T_W = 7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_POWER = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_ACT = 4'b0100,
    ST_PRE = 4'b1000
  } dnc_state_e;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW = 2'h2,
    OP_REFRESH = 2'h3
  } dnc_op_e;
endpackage

// ===== src/dnc_ctrl.sv
// Host-side cycle controller for a 16K x 4 multiplexed-address DRAM
// Overview of operation
// - After over 2 ms idle, issue eight cycles
// - Keep row-to-column delay below maximum
// - Column high before row low always
// - Write strobe stays high through read end
// - Space read-modify-write cycles by 295 ns
// - Drive data only 25 ns after gate high
// - Refresh all 128 rows every 2 ms
// - Wait 500 us then eight wake cycles
`timescale 1ns/10ps
module dnc_ctrl
  import dnc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int IDLE_LIMIT_CYCLES = IDLE_LIMIT_CYC,
  parameter int REF_INT_CYCLES = REF_INT_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // User request side
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_rmw_i,
  input wire logic [ROW_BITS+COL_BITS-1:0] req_addr_i,
  input wire logic [DQ_BITS-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic [DQ_BITS-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic init_done_o,
  // DRAM pins
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [ROW_BITS-1:0] addr_o,
  input wire logic [DQ_BITS-1:0] dq_i,
  output logic [DQ_BITS-1:0] dq_o,
  output logic dq_oe_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  dnc_state_e state_q, state_d;
  dnc_op_e op_q, op_d;
  logic [T_W-1:0] t_q, t_d;
  logic [T_W-1:0] p_q, p_d;
  logic [CNT_W-1:0] pwr_q, pwr_d;
  logic [CNT_W-1:0] idle_q, idle_d;
  logic [CNT_W-1:0] ref_q, ref_d;
  logic ref_pend_q, ref_pend_d;
  logic [3:0] wake_q, wake_d;
  logic init_q, init_d;
  logic [ROW_BITS-1:0] rfrow_q, rfrow_d;
  logic [ROW_BITS+COL_BITS-1:0] addr_q, addr_d;
  logic [DQ_BITS-1:0] wdata_q, wdata_d;
  logic [DQ_BITS-1:0] dq_s1_q, dq_s2_q;
  logic [DQ_BITS-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic ras_n_q, cas_n_q, we_n_q, oe_n_q, dq_oe_q;
  logic [ROW_BITS-1:0] pa_q;
  logic [DQ_BITS-1:0] dq_q;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire is_rd = (op_q == OP_READ);
  wire is_wr = (op_q == OP_WRITE);
  wire is_rmw = (op_q == OP_RMW);
  wire is_ref = (op_q == OP_REFRESH);
  wire in_act = (state_q == ST_ACT);
  wire in_pre = (state_q == ST_PRE);
  wire [T_W-1:0] end_t = is_rmw ? T_W'(RMW_END_T) : is_rd ? T_W'(RD_END_T) : T_W'(WR_END_T);
  wire [T_W-1:0] cyc_t = is_rmw ? T_W'(RWC_CYC) : T_W'(RC_CYC);
  wire act_done = in_act && (t_q >= end_t);
  // Precharge ends on both the high width and the whole cycle time
  wire pre_done = in_pre && (p_q >= T_W'(RP_CYC - 1)) && (t_q >= cyc_t - T_W'(1));
  wire col_phase = (t_q >= T_W'(RCD_CYC));
  // Column address goes out a cycle before its strobe, so the pins never change on the strobe edge
  wire col_addr_phase = (t_q >= T_W'(RCD_CYC - 1));
  wire need_ref = ref_pend_q || (wake_q != 4'h0);
  wire idle_ok = (state_q == ST_IDLE) && init_q;
  wire take_user = idle_ok && !need_ref && req_i;
  wire start_ref = (state_q == ST_IDLE) && need_ref;
  wire sample_now = in_act && (is_rd || is_rmw) && (t_q == T_W'(SAMPLE_T));
  wire ref_tick = (ref_q >= CNT_W'(REF_INT_CYCLES - 1));
  wire idle_hit = (idle_q >= CNT_W'(IDLE_LIMIT_CYCLES - 1));
  wire [ROW_BITS-1:0] row_addr = is_ref ? rfrow_q : addr_q[ROW_BITS-1:0];
  // Row address settles a cycle ahead of the row strobe fall
  wire [ROW_BITS-1:0] next_row = start_ref ? rfrow_q : take_user ? req_addr_i[ROW_BITS-1:0] : row_addr;

  // Pin values for the next cycle
  wire ras_n_d = !in_act;
  // CAS only moves inside a row cycle, so it is high before every row fall
  wire cas_n_d = !(in_act && !is_ref && col_phase && !act_done);
  // Read gate opens with the column strobe and closes right after sampling
  wire oe_n_d = !(in_act && (is_rd || is_rmw) && col_phase && (t_q <= T_W'(SAMPLE_T)));
  // Early write drops write strobe with the row strobe, ahead of CAS
  wire we_early = in_act && is_wr && !act_done;
  // Late write strobe waits for read data and the gate turnaround
  wire we_late = in_act && is_rmw && (t_q >= T_W'(RMW_WE_T)) && (t_q >= T_W'(RWD_CYC)) && !act_done;
  // Reads and refreshes never lower write strobe
  wire we_n_d = !(we_early || we_late);
  wire dq_oe_d = we_early || (in_act && is_rmw && (t_q >= T_W'(RMW_WE_T)) && !act_done);
  wire [ROW_BITS-1:0] pa_d = (in_act && col_addr_phase) ? addr_q[ROW_BITS+COL_BITS-1:ROW_BITS] : next_row;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    t_d = t_q;
    p_d = p_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    init_d = init_q;
    rfrow_d = rfrow_q;
    wake_d = wake_q;
    pwr_d = pwr_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    case (state_q)
      ST_POWER: begin
        pwr_d = pwr_q + CNT_W'(1);
        if (pwr_q >= CNT_W'(POWERUP_CYCLES - 1)) begin
          wake_d = 4'(WAKE_CYCLES);
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        t_d = '0;
        if (start_ref) begin
          op_d = OP_REFRESH;
          state_d = ST_ACT;
        end else if (take_user) begin
          op_d = req_rmw_i ? OP_RMW : (req_write_i ? OP_WRITE : OP_READ);
          addr_d = req_addr_i;
          wdata_d = req_wdata_i;
          state_d = ST_ACT;
        end
      end
      ST_ACT: begin
        t_d = t_q + T_W'(1);
        p_d = '0;
        if (sample_now) begin
          rdata_d = dq_s2_q;
          rvalid_d = 1'b1;
        end
        if (act_done) begin
          state_d = ST_PRE;
        end
      end
      ST_PRE: begin
        t_d = t_q + T_W'(1);
        p_d = p_q + T_W'(1);
        if (pre_done) begin
          state_d = ST_IDLE;
          if (is_ref) begin
            rfrow_d = rfrow_q + ROW_BITS'(1);
            if (wake_q != 4'h0) begin
              wake_d = wake_q - 4'h1;
            end
            if (wake_q == 4'h1) begin
              init_d = 1'b1;
            end
          end
        end
      end
      default: begin
        state_d = ST_POWER;
      end
    endcase
    // Long row-strobe silence restarts the wake sequence
    if (idle_hit && init_q) begin
      wake_d = 4'(WAKE_CYCLES);
    end
  end

  // Refresh pacing and idle timing; a new tick beats the clear
  assign ref_d = ref_tick ? '0 : ref_q + CNT_W'(1);
  assign ref_pend_d = (ref_tick && init_q) || (ref_pend_q && !(start_ref && wake_q == 4'h0));
  // Idle limit covers the case where pacing is slower than the row-strobe gap
  assign idle_d = (!ras_n_q || idle_hit) ? '0 : idle_q + CNT_W'(1);
  assign req_ready_o = idle_ok && !need_ref;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_POWER;
      op_q <= OP_READ;
      t_q <= '0;
      p_q <= '0;
      pwr_q <= '0;
      idle_q <= '0;
      ref_q <= '0;
      ref_pend_q <= 1'b0;
      wake_q <= 4'h0;
      init_q <= 1'b0;
      rfrow_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      t_q <= t_d;
      p_q <= p_d;
      pwr_q <= pwr_d;
      idle_q <= idle_d;
      ref_q <= ref_d;
      ref_pend_q <= ref_pend_d;
      wake_q <= wake_d;
      init_q <= init_d;
      rfrow_q <= rfrow_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
      pa_q <= '0;
      dq_q <= '0;
    end else begin
      ras_n_q <= ras_n_d;
      cas_n_q <= cas_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      dq_oe_q <= dq_oe_d;
      pa_q <= pa_d;
      dq_q <= wdata_q;
    end
  end

  // Pin data comes from another timing domain
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign ras_n_o = ras_n_q;
  assign cas_n_o = cas_n_q;
  assign we_n_o = we_n_q;
  assign oe_n_o = oe_n_q;
  assign addr_o = pa_q;
  assign dq_o = dq_q;
  assign dq_oe_o = dq_oe_q;
  assign rd_data_o = rdata_q;
  assign rd_valid_o = rvalid_q;
  assign init_done_o = init_q;

endmodule

// ===== tb/dnc_ctrl_checker.sv
// Pin protocol checker for the DRAM cycle controller
`timescale 1ns/10ps
module dnc_ctrl_checker
  import dnc_pkg::*;
#(
  parameter int REF_INT_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Watched outputs
  input wire logic rd_valid_o,
  input wire logic init_done_o,
  input wire logic ras_n_o,
  input wire logic cas_n_o,
  input wire logic we_n_o,
  input wire logic oe_n_o,
  input wire logic dq_oe_o
);
  logic ras_q, we_q, rmw_q;
  logic [3:0] falls_q;
  logic [CNT_W-1:0] since_q;
  wire fall_w = ras_q && !ras_n_o;
  // Counts saturate so a long power-up wait cannot wrap
  always_ff @(posedge ref_clk_i) begin
    ras_q <= ras_n_o;
    we_q <= we_n_o;
    if (rst_i) begin
      since_q <= 20'h0_0000;
      falls_q <= 4'h0;
      rmw_q <= 1'b0;
    end else begin
      since_q <= fall_w ? 20'h0_0001 : since_q + CNT_W'(~&since_q);
      falls_q <= falls_q + 4'(fall_w && ~&falls_q);
      rmw_q <= !fall_w && (rmw_q || (we_q && !we_n_o && !cas_n_o));
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_late_we;
    $fell(we_n_o) && !cas_n_o;
  endsequence
  ras_cas_delay_a: assert property ($fell(cas_n_o) |-> !$past(ras_n_o, 6) && $past(ras_n_o, 12))
    else $error("row to column delay wrong");
  cas_high_ras_a: assert property ($fell(ras_n_o) |-> cas_n_o && $past(cas_n_o))
    else $error("column low at row fall");
  read_we_hold_a: assert property ($rose(cas_n_o) && $past(!oe_n_o) |-> we_n_o ##1 we_n_o)
    else $error("write strobe low at read end");
  early_write_a: assert property ($fell(cas_n_o) && !we_n_o |-> dq_oe_o && oe_n_o && !$past(we_n_o, 6))
    else $error("early write setup wrong");
  late_write_a: assert property (s_late_we |-> $past(!cas_n_o, 18) && $past(!ras_n_o, 30) && oe_n_o)
    else $error("late write too early");
  read_sample_a: assert property (rd_valid_o |-> $past(ras_n_o, 29) && !$past(ras_n_o, 28) && !$past(oe_n_o, 3) && !$past(cas_n_o, 3))
    else $error("read data sampled outside window");
  cycle_space_a: assert property ($fell(ras_n_o) |-> since_q >= RC_CYC && (!rmw_q || since_q >= RWC_CYC))
    else $error("cycles too close");
  gate_drive_a: assert property (dq_oe_o |-> oe_n_o && $past(oe_n_o, 5))
    else $error("data driven too soon after gate");
  refresh_pace_a: assert property (init_done_o |-> since_q <= REF_INT_CYCLES + 3 * RWC_CYC)
    else $error("refresh interval exceeded");
  wake_count_a: assert property ($rose(init_done_o) |-> falls_q == WAKE_CYCLES)
    else $error("wake cycle count wrong");
  rmw_seen_c: cover property (s_late_we);
endmodule
bind dnc_ctrl dnc_ctrl_checker #(.REF_INT_CYCLES(REF_INT_CYCLES)) i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .rd_valid_o(rd_valid_o), .init_done_o(init_done_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
  .oe_n_o(oe_n_o), .dq_oe_o(dq_oe_o));

// ===== tb/dnc_dram_model.sv
// Behavioural model of the 16K x 4 DRAM
`timescale 1ns/10ps
module dnc_dram_model #(
  parameter real AGE_NS = 2000000.0
) (
  // Strobes and address
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [6:0] addr_i,
  // Shared data line
  input wire logic [3:0] din_i,
  output logic [3:0] q_o,
  output logic q_oe_o
);
  logic [3:0] mem [0:16383];
  logic [6:0] row_q, col_q;
  logic early_q = 1'b0, stale_q = 1'b0;
  logic [3:0] last_q = 4'h5;
  realtime t_ras, t_cas, t_ref [0:127];
  initial for (int i = 0; i < 128; i++) t_ref[i] = 0.0;
  always @(negedge ras_n_i) begin
    row_q = addr_i;
    t_ras = $realtime;
    // A row left too long loses its cells
    if (t_ras - t_ref[addr_i] > AGE_NS) stale_q = 1'b1;
    t_ref[addr_i] = t_ras;
  end
  always @(negedge cas_n_i) begin
    col_q = addr_i;
    t_cas = $realtime;
    early_q = !we_n_i;
    if (!we_n_i) mem[{addr_i, row_q}] = din_i;
  end
  always @(negedge we_n_i) if (!cas_n_i && !early_q) begin
    #1 mem[{col_q, row_q}] = din_i;
  end
  always #1 begin
    q_oe_o = !ras_n_i && !cas_n_i && !oe_n_i && !early_q;
    if (q_oe_o && $realtime - t_ras >= 120.0 && $realtime - t_cas >= 60.0) begin
      q_o = stale_q ? ~mem[{col_q, row_q}] : mem[{col_q, row_q}];
      last_q = q_o;
    end else q_o = ~last_q;
  end
endmodule

// ===== tb/dnc_ctrl_tb.sv
// Self-checking bench for the DRAM cycle controller
`timescale 1ns/10ps
module dnc_ctrl_tb;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, req_write_i = 1'b0, req_rmw_i = 1'b0;
  logic [13:0] req_addr_i = 14'h0000;
  logic [3:0] req_wdata_i = 4'h0, rd_data_o, dq_o, m_q;
  logic req_ready_o, rd_valid_o, init_done_o, ras_n_o, cas_n_o, we_n_o, oe_n_o, dq_oe_o, m_oe;
  logic [6:0] addr_o;
  wire logic [3:0] dq_w = dq_oe_o ? dq_o : m_q;
  logic [3:0] shadow [0:16383];
  logic [3:0] exp_q [$];
  logic [13:0] addr_a [0:7];
  integer seed = 32'h4a9f;
  int fails = 0, n_compared = 0, cyc = 0, i;
  always #2.5 ref_clk_i = ~ref_clk_i;
  dnc_ctrl #(.POWERUP_CYCLES(50), .IDLE_LIMIT_CYCLES(3000), .REF_INT_CYCLES(200)) i_dut (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i), .req_rmw_i(req_rmw_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .init_done_o(init_done_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o),
    .addr_o(addr_o), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  dnc_dram_model #(.AGE_NS(150000.0)) i_mem (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o), .we_n_i(we_n_o),
    .oe_n_i(oe_n_o), .addr_i(addr_o), .din_i(dq_w), .q_o(m_q), .q_oe_o(m_oe));
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
      fails++;
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Request stays up until an edge sees ready; expectation noted at take
  task automatic do_req(input logic wr, input logic rm, input logic [13:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    req_write_i <= wr;
    req_rmw_i <= rm;
    req_addr_i <= a;
    req_wdata_i <= d;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 9000);
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    if (!wr || rm) exp_q.push_back(shadow[a]);
    if (wr || rm) shadow[a] = d;
  endtask
  task automatic wait_init;
    int n;
    n = 0;
    @(negedge ref_clk_i);
    check(8'h78, 8'({ras_n_o, cas_n_o, we_n_o, oe_n_o, dq_oe_o, init_done_o, req_ready_o}));
    while (init_done_o !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(8'(init_done_o), 8'h01);
  endtask
  always @(negedge ref_clk_i) if (rd_valid_o === 1'b1) begin
    if (exp_q.size() == 0) check(8'h00, 8'hff);
    else check(8'(exp_q.pop_front()), 8'(rd_data_o));
  end
  // Shared data pins must never be driven from both ends at once
  always @(negedge ref_clk_i) if (dq_oe_o === 1'b1) check(8'h00, 8'(m_oe));
  // Ceiling well above the planned run of about 36000 cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_init;
    for (i = 0; i < 8; i++) begin
      addr_a[i] = (i == 0) ? 14'h0000 : (i == 7) ? 14'h3fff : 14'($random(seed));
      do_req(1'b1, 1'b0, addr_a[i], 4'($random(seed)));
    end
    for (i = 0; i < 8; i++) do_req(1'b0, 1'b0, addr_a[i], 4'h0);
    for (i = 0; i < 8; i++) do_req(1'b0, 1'b1, addr_a[i], 4'($random(seed)));
    repeat (60) @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_init;
    repeat (32000) @(posedge ref_clk_i);
    for (i = 0; i < 8; i++) do_req(1'b0, 1'b0, addr_a[i], 4'h0);
    repeat (60) @(posedge ref_clk_i);
    check(8'h00, 8'(exp_q.size()));
    complete_run;
  end
endmodule
